// ---- verilog/dbs_defs.svh ----
/*
 * constants for the dual buck start-up sequencer: register offsets, field
 * positions, reset values and timing counts.
 * assumes inclusion by bare name from the design and bench top files.
 */
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DBS_OFF_CTRL      12'h000
`define DBS_OFF_STATUS    12'h004
`define DBS_OFF_FREQ      12'h008
`define DBS_OFF_SS_CH0    12'h00c
`define DBS_OFF_SS_CH1    12'h010
`define DBS_OFF_EVENTS    12'h014
`define DBS_OFF_ID        12'h018

// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define DBS_CTRL_SYNC_EN  0
`define DBS_CTRL_RST      32'h0000_0001

// ---------------------------------------------------------------
// events fields (write one to clear)
// ---------------------------------------------------------------
`define DBS_EV_BIAS_LOST  0
`define DBS_EV_FAULT0     1
`define DBS_EV_FAULT1     2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DBS_CLK_MHZ       200
// free-running period in clocks: 600 kHz at 200 MHz
`define DBS_FREQ_KHZ_DEF  600
`define DBS_PER_DEF       (`DBS_CLK_MHZ * 1000 / `DBS_FREQ_KHZ_DEF)
`define DBS_PER_MIN       12'd182
`define DBS_PER_MAX       12'd741
// pre-bias: 16 pulses per step, 8 steps of one eighth
`define DBS_PB_PULSES     16
`define DBS_PB_STEPS      8
// soft-start reference in uV: 0.2 mV/us is 200 uV per us, so at 200 MHz
// the reference climbs one uV every clock
`define DBS_SS_SLOPE_UV_US 200
`define DBS_SS_TICK       (`DBS_CLK_MHZ / `DBS_SS_SLOPE_UV_US)
`define DBS_SS_FINAL_UV   21'd1500000
`define DBS_SS_LO_UV      21'd150000
`define DBS_SS_HI_UV      21'd650000
// arbitrary value
`define DBS_ID_DEF        32'h0000_5a5a

`endif

// ---- verilog/dbs_pkg.sv ----
/*
 * types for the dual buck start-up sequencer.
 * assumes dbs_defs.svh is on the include path.
 */
package dbs_pkg;
	typedef enum logic [2:0] {
		CH_OFF,
		CH_ASYNC,
		CH_PREBIAS,
		CH_RUN,
		CH_FAULT
	} dbs_state_t;

	typedef struct packed {
		logic overcurrent_guard;
		logic overvoltage_guard;
	} dbs_fault_t;

	typedef struct packed {
		logic high_side_switch;
		logic low_side_switch;
	} dbs_gate_t;
endpackage

// ---- verilog/dbs_sequencer.sv ----
/*
 * dual buck start-up sequencer: lockout, power-on-ready, per-channel pre-bias
 * stepped start, digital soft-start, frequency selection and smooth sync.
 * assumes all level inputs are comparator outputs already synchronous to aclk,
 * and an axi4-lite master with one outstanding transfer per direction.
 */
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "dbs_defs.svh"

module dbs_sequencer (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 bias_ok,
	input  wire logic [1:0]           enable_ok,
	input  wire dbs_pkg::dbs_fault_t  fault_in [2],
	input  wire logic                 overtemp,
	input  wire logic                 sync_in,
	output dbs_pkg::dbs_gate_t        gate_out [2],
	output logic                      power_on_ready,
	output logic [20:0]               ss_ref_uv [2],
	output logic [1:0]                startup_done,
	output logic [15:0]               ramp_step,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	// ---------------------------------------------------------------
	// registers and shared state
	// ---------------------------------------------------------------
	logic        sync_en_r;
	logic [11:0] free_per_r;
	logic [2:0]  events_r;
	logic [11:0] per_r;
	logic [11:0] phase_r;
	logic [11:0] sync_cnt_r;
	logic [11:0] sync_per_r;
	logic        sync_d_r;
	logic        sync_seen_r;
	logic        por_r;
	logic        bias_d_r;
	logic        cycle_start;

	function automatic logic [11:0] clamp_per(input logic [11:0] p);
		if (p < `DBS_PER_MIN)
			clamp_per = `DBS_PER_MIN;
		else if (p > `DBS_PER_MAX)
			clamp_per = `DBS_PER_MAX;
		else
			clamp_per = p;
	endfunction

	// ---------------------------------------------------------------
	// power-on-ready and bias lockout event
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_r    <= 1'b0;
			bias_d_r <= 1'b0;
		end else begin
			por_r    <= bias_ok & (|enable_ok) & ~overtemp;
			bias_d_r <= bias_ok;
		end
	end
	assign power_on_ready = por_r;

	// ---------------------------------------------------------------
	// oscillator with smooth sync
	// ---------------------------------------------------------------
	// sync period measured edge to edge; the live period steps one clock per
	// cycle toward its target so the frequency never jumps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_d_r    <= 1'b0;
			sync_cnt_r  <= 12'h000;
			sync_per_r  <= 12'h000;
			sync_seen_r <= 1'b0;
		end else begin
			sync_d_r <= sync_in;
			if (sync_in & ~sync_d_r) begin
				sync_per_r  <= sync_cnt_r + 12'h001;
				sync_cnt_r  <= 12'h000;
				sync_seen_r <= 1'b1;
			end else if (sync_cnt_r == `DBS_PER_MAX) begin
				sync_seen_r <= 1'b0; // clock removed
			end else begin
				sync_cnt_r <= sync_cnt_r + 12'h001;
			end
		end
	end

	logic [11:0] target_per;
	assign target_per = (sync_en_r & sync_seen_r) ? clamp_per(sync_per_r) : clamp_per(free_per_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_r   <= 12'(`DBS_PER_DEF);
			phase_r <= 12'h000;
		end else begin
			phase_r <= (phase_r + 12'h001 >= per_r) ? 12'h000 : phase_r + 12'h001;
			if (cycle_start) begin
				if (per_r < target_per)
					per_r <= per_r + 12'h001;
				else if (per_r > target_per)
					per_r <= per_r - 12'h001;
			end
		end
	end
	assign cycle_start = (phase_r == 12'h000);

	// ramp rises per clock by a step inversely proportional to the period
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ramp_step <= 16'h0000;
		else
			ramp_step <= 16'(32'hffff / {20'h00000, per_r});
	end

	// ---------------------------------------------------------------
	// per-channel sequencer
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			dbs_pkg::dbs_state_t state_r;
			logic [3:0]          pcount_r;
			logic [3:0]          step_r;
			logic [20:0]         ref_r;
			logic [9:0]          tick_r;
			logic                ch_ok;
			logic                flt;
			logic [11:0]         ls_width;

			assign ch_ok = bias_ok & enable_ok[g] & por_r & ~overtemp;
			// guards are honoured in every running state including the ramp
			assign flt   = fault_in[g].overcurrent_guard | fault_in[g].overvoltage_guard | overtemp;
			assign ls_width = 12'((32'(per_r) * 32'(step_r)) >> 3);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					state_r  <= dbs_pkg::CH_OFF;
					pcount_r <= 4'h0;
					step_r   <= 4'h1;
				end else begin
					case (state_r)
						dbs_pkg::CH_OFF: begin
							pcount_r <= 4'h0;
							step_r   <= 4'h1;
							if (ch_ok & ~flt)
								state_r <= dbs_pkg::CH_ASYNC;
						end
						dbs_pkg::CH_ASYNC: begin
							// first high side pulse has gone out, so the low side may follow
							if (gate_out[g].high_side_switch)
								state_r <= dbs_pkg::CH_PREBIAS;
						end
						dbs_pkg::CH_PREBIAS: begin
							if (cycle_start) begin
								pcount_r <= pcount_r + 4'h1;
								if (pcount_r == 4'(`DBS_PB_PULSES - 1)) begin
									if (step_r == 4'(`DBS_PB_STEPS))
										state_r <= dbs_pkg::CH_RUN;
									else
										step_r <= step_r + 4'h1;
								end
							end
						end
						dbs_pkg::CH_RUN: ;
						dbs_pkg::CH_FAULT: begin
							if (~flt)
								state_r <= dbs_pkg::CH_OFF;
						end
						default: state_r <= dbs_pkg::CH_OFF;
					endcase
					if (state_r != dbs_pkg::CH_OFF && state_r != dbs_pkg::CH_FAULT) begin
						if (flt)
							state_r <= dbs_pkg::CH_FAULT;
						else if (~ch_ok)
							state_r <= dbs_pkg::CH_OFF;
					end
				end
			end

			// soft-start reference, reset to zero whenever the channel is not up
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ref_r  <= 21'h000000;
					tick_r <= 10'h000;
				end else if (state_r == dbs_pkg::CH_OFF || state_r == dbs_pkg::CH_FAULT || ~ch_ok) begin
					ref_r  <= 21'h000000;
					tick_r <= 10'h000;
				end else if (tick_r == 10'(`DBS_SS_TICK - 1)) begin
					tick_r <= 10'h000;
					if (ref_r < `DBS_SS_FINAL_UV)
						ref_r <= ref_r + 21'h000001;
				end else begin
					tick_r <= tick_r + 10'h001;
				end
			end
			assign ss_ref_uv[g]    = ref_r;
			assign startup_done[g] = (ref_r >= `DBS_SS_HI_UV);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					gate_out[g] <= '0;
				end else begin
					gate_out[g].high_side_switch <= state_r != dbs_pkg::CH_OFF && state_r != dbs_pkg::CH_FAULT
						&& phase_r < (per_r >> 1) && ch_ok && ~flt;
					// low side stays off in asynchronous start and never enters the high half,
					// so even the widest pre-bias step cannot overlap the high side
					gate_out[g].low_side_switch <= ch_ok && ~flt && phase_r >= (per_r >> 1)
						&& ((state_r == dbs_pkg::CH_PREBIAS && phase_r >= per_r - ls_width)
						|| state_r == dbs_pkg::CH_RUN);
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [11:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        do_write;

	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
	assign do_write      = aw_hold_r & w_hold_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r    <= 1'b0;
			w_hold_r     <= 1'b0;
			aw_addr_r    <= 12'h000;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_r == `DBS_OFF_CTRL || aw_addr_r == `DBS_OFF_FREQ
					|| aw_addr_r == `DBS_OFF_EVENTS) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_en_r  <= 1'b1;
			free_per_r <= 12'(`DBS_PER_DEF);
		end else if (do_write) begin
			if (aw_addr_r == `DBS_OFF_CTRL && w_strb_r[0])
				sync_en_r <= w_data_r[`DBS_CTRL_SYNC_EN];
			if (aw_addr_r == `DBS_OFF_FREQ) begin
				if (w_strb_r[0])
					free_per_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1])
					free_per_r[11:8] <= w_data_r[11:8];
			end
		end
	end

	// sticky events; a new event wins over a same-cycle clear
	logic [2:0] ev_set;
	logic [2:0] ev_clr;
	assign ev_set = {gen_ch[1].state_r != dbs_pkg::CH_FAULT && gen_ch[1].flt && gen_ch[1].state_r != dbs_pkg::CH_OFF,
	                 gen_ch[0].state_r != dbs_pkg::CH_FAULT && gen_ch[0].flt && gen_ch[0].state_r != dbs_pkg::CH_OFF,
	                 bias_d_r & ~bias_ok};
	assign ev_clr = (do_write && aw_addr_r == `DBS_OFF_EVENTS && w_strb_r[0]) ? w_data_r[2:0] : 3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			events_r <= 3'h0;
		else
			events_r <= (events_r & ~ev_clr) | ev_set;
	end

	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				`DBS_OFF_CTRL:   s_axi_rdata <= {31'h0, sync_en_r};
				`DBS_OFF_STATUS: s_axi_rdata <= {20'h0, startup_done, sync_seen_r, por_r,
				                                 1'b0, gen_ch[1].state_r, 1'b0, gen_ch[0].state_r};
				`DBS_OFF_FREQ:   s_axi_rdata <= {4'h0, per_r, 4'h0, free_per_r};
				`DBS_OFF_SS_CH0: s_axi_rdata <= {11'h0, gen_ch[0].ref_r};
				`DBS_OFF_SS_CH1: s_axi_rdata <= {11'h0, gen_ch[1].ref_r};
				`DBS_OFF_EVENTS: s_axi_rdata <= {29'h0, events_r};
				`DBS_OFF_ID:     s_axi_rdata <= `DBS_ID_DEF; // arbitrary value
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // dbs_sequencer

// ---- tb/dbs_sequencer_props.sv ----
/* assertions on the ports of the start-up sequencer.
 * assumes a bind from the bench top file; one clock, synchronous low reset. */
`timescale 1ns/10ps
module dbs_sequencer_props (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                bias_ok,
	input wire logic [1:0]          enable_ok,
	input wire dbs_pkg::dbs_fault_t fault_in [2],
	input wire logic                overtemp,
	input wire dbs_pkg::dbs_gate_t  gate_out [2],
	input wire logic                power_on_ready,
	input wire logic [20:0]         ss_ref_uv [2],
	input wire logic [1:0]          startup_done
);
	logic       all_ok;
	logic [1:0] hs_seen_r;

	assign all_ok = bias_ok && |enable_ok && !overtemp;

	// forgotten when the channel enable or bias drops, so each such restart must pulse the high side again
	always_ff @(posedge aclk) begin
		for (int c = 0; c < 2; c++) begin
			if (!aresetn || !enable_ok[c] || !bias_ok)
				hs_seen_r[c] <= 1'b0;
			else if (gate_out[c].high_side_switch)
				hs_seen_r[c] <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_bias_low;
		!bias_ok ##1 !bias_ok;
	endsequence
	sequence s_temp_high;
		overtemp ##1 overtemp;
	endsequence

	a_bias_gates_off: assert property (s_bias_low |-> gate_out[0] == '0 && gate_out[1] == '0)
		else $error("gates driven while bias locked out");
	a_en_gates_off: assert property (!enable_ok[0] ##1 !enable_ok[0] |-> gate_out[0] == '0)
		else $error("channel 0 gates driven while disabled");
	a_por_level: assert property (##1 $stable(all_ok) |-> power_on_ready == all_ok)
		else $error("power-on-ready differs from input state");
	a_low_after_high: assert property ($rose(gate_out[0].low_side_switch) |-> hs_seen_r[0])
		else $error("low side switched before first high side pulse");
	a_ss_needs_por: assert property (ss_ref_uv[0] > $past(ss_ref_uv[0]) |->
		$past(power_on_ready) || $past(power_on_ready, 2))
		else $error("soft-start ramp moved without power-on-ready");
	a_ss_step: assert property ($changed(ss_ref_uv[0]) && ss_ref_uv[0] != '0 |->
		ss_ref_uv[0] - $past(ss_ref_uv[0]) == 21'd1)
		else $error("soft-start reference jumped");
	a_done_level: assert property (##1 $stable(ss_ref_uv[1] >= 21'd650000) |->
		startup_done[1] == (ss_ref_uv[1] >= 21'd650000))
		else $error("start-up done flag disagrees with reference");
	a_temp_off: assert property (s_temp_high |-> gate_out[0] == '0 && gate_out[1] == '0 && !power_on_ready)
		else $error("gates driven during overtemperature");
	a_fault_off: assert property (fault_in[1] != '0 ##1 fault_in[1] != '0 |-> gate_out[1] == '0)
		else $error("channel 1 gates driven during fault");
endmodule // dbs_sequencer_props

// ---- tb/dbs_sys_ctrl.sv ----
/* system controller model: channel enables and an external sync clock.
 * assumes the bench changes its requests by non-blocking assignment. */
`timescale 1ns/10ps
module dbs_sys_ctrl (
	input  wire logic       aclk,
	input  wire logic [1:0] en_req,
	input  wire logic       sync_on,
	output logic [1:0]      enable_ok,
	output logic            sync_in
);
	localparam int sync_per = 400;
	localparam int sync_hi  = 40;
	int cnt_r;

	// each enable moves alone, so one channel may stop while the other runs
	always @(posedge aclk)
		enable_ok <= en_req;
	// sync only after turn-on, so the free period stays set; pin idles low
	always @(posedge aclk) begin
		cnt_r <= (sync_on && cnt_r < sync_per - 1) ? cnt_r + 1 : 0;
		sync_in <= sync_on && cnt_r < sync_hi;
	end
endmodule // dbs_sys_ctrl

// ---- tb/dbs_sequencer_tb_top.sv ----
/* self-checking bench for the start-up sequencer over its register bus.
 * assumes the package, defs header, checker and partner model compile first. */
`timescale 1ns/10ps
`include "dbs_defs.svh"
module dbs_sequencer_tb_top;
	logic                aclk, aresetn, bias_ok, overtemp, sync_on, sync_in, power_on_ready;
	logic [1:0]          en_req, enable_ok, startup_done, bresp, rresp, r;
	dbs_pkg::dbs_fault_t fault_in [2];
	dbs_pkg::dbs_gate_t  gate_out [2];
	logic [20:0]         ss_ref_uv [2];
	logic [20:0]         s1;
	logic [15:0]         ramp_step;
	logic [11:0]         awaddr, araddr;
	logic [31:0]         wdata, rdata, d;
	logic                awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int                  bad_count, check_count, hs_n, ls_n;

	dbs_sys_ctrl i_dbs_sys_ctrl (.aclk(aclk), .en_req(en_req), .sync_on(sync_on), .enable_ok(enable_ok),
		.sync_in(sync_in));
	dbs_sequencer i_dbs_sequencer (.aclk(aclk), .aresetn(aresetn), .bias_ok(bias_ok), .enable_ok(enable_ok),
		.fault_in(fault_in), .overtemp(overtemp), .sync_in(sync_in), .gate_out(gate_out),
		.power_on_ready(power_on_ready), .ss_ref_uv(ss_ref_uv), .startup_done(startup_done),
		.ramp_step(ramp_step), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	always #2.5 aclk = ~aclk;

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// each handshake is judged on the values that stand at the completing rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic b_t;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			b_t = bvalid;
			r = bresp;
		end while (!b_t);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		logic r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			r_t = rvalid;
			d = rdata;
			r = rresp;
		end while (!r_t);
		rready <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		{aclk, aresetn, bias_ok, overtemp, sync_on, en_req} = '0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		fault_in[0] = '0;
		fault_in[1] = '0;
		bad_count = 0;
		check_count = 0;
		cyc(16);
		aresetn <= 1'b1;
		rd(`DBS_OFF_CTRL);
		chk("ctrl reset", 32'h1, d);
		rd(`DBS_OFF_FREQ);
		chk("free period reset", 32'd333, d[11:0]);
		rd(12'h0fc);
		chk("unmapped read", 32'h2, {d[29:0], r});
		wr(12'h0fc, 32'hffff_ffff);
		chk("unmapped write", 32'h2, r);
		chk("por idle", 32'h0, power_on_ready);
		bias_ok <= 1'b1;
		en_req <= 2'b01;
		cyc(2500);
		s1 = ss_ref_uv[0];
		chk("por on", 32'h1, power_on_ready);
		chk("ss1 idle", 32'h0, ss_ref_uv[1]);
		// still in the first pre-bias step: three whole periods and one clock
		hs_n = 0;
		ls_n = 0;
		repeat (3 * `DBS_PER_DEF + 1) begin
			@(posedge aclk);
			hs_n += gate_out[0].high_side_switch;
			ls_n += gate_out[0].low_side_switch;
		end
		chk("high width", 32'h1, hs_n inside {[3 * (`DBS_PER_DEF / 2):3 * (`DBS_PER_DEF / 2) + 1]});
		chk("low width", 32'h1, ls_n inside {[3 * (`DBS_PER_DEF / 8):3 * (`DBS_PER_DEF / 8) + 1]});
		// accept the slow end of the typical slope as well
		chk("ss0 slope", 32'h1, ss_ref_uv[0] - s1 inside {[880:1000]});
		en_req <= 2'b10;
		cyc(1000);
		chk("ss0 off", 32'h0, ss_ref_uv[0]);
		chk("gates0 off", 32'h0, gate_out[0]);
		chk("ss1 runs", 32'h1, ss_ref_uv[1] > 21'd800);
		for (int k = 0; k < 3; k++) begin
			fault_in[1] <= dbs_pkg::dbs_fault_t'(k == 0 ? 2'b10 : k == 1 ? 2'b01 : 2'b00);
			overtemp <= (k == 2);
			cyc(4);
			chk("fault gates", 32'h0, gate_out[1]);
			chk("fault ss", 32'h0, ss_ref_uv[1]);
			chk("por temp", k != 2, power_on_ready);
			rd(`DBS_OFF_EVENTS);
			// overtemperature stops the running channel as a fault too
			chk("fault event", 32'h1, d[`DBS_EV_FAULT1]);
			fault_in[1] <= '0;
			overtemp <= 1'b0;
			wr(`DBS_OFF_EVENTS, 32'h6);
			rd(`DBS_OFF_EVENTS);
			chk("event cleared", 32'h0, d[2:1]);
			cyc(300);
			chk("ss1 restart", 32'h1, ss_ref_uv[1] inside {[1:320]});
		end
		bias_ok <= 1'b0;
		cyc(3);
		chk("por bias", 32'h0, power_on_ready);
		chk("gates bias", 32'h0, gate_out[1]);
		rd(`DBS_OFF_EVENTS);
		chk("bias event", 32'h1, d[`DBS_EV_BIAS_LOST]);
		wr(`DBS_OFF_EVENTS, 32'h1);
		bias_ok <= 1'b1;
		cyc(500);
		chk("ss1 resume", 32'h1, ss_ref_uv[1] != 21'h0);
		wr(`DBS_OFF_FREQ, 32'd182);
		rd(`DBS_OFF_FREQ);
		chk("free period", 32'd182, d[11:0]);
		cyc(3000);
		rd(`DBS_OFF_FREQ);
		chk("ramp step", 32'hffff / d[27:16], ramp_step);
		sync_on <= 1'b1;
		cyc(2000);
		rd(`DBS_OFF_FREQ);
		chk("sync slew", 32'h1, d[27:16] > 12'd182 && d[27:16] < 12'd400);
		rd(`DBS_OFF_STATUS);
		chk("sync seen", 32'h1, d[9]);
		sync_on <= 1'b0;
		cyc(2000);
		rd(`DBS_OFF_STATUS);
		chk("sync lost", 32'h0, d[9]);
		stop_test();
	end
endmodule // dbs_sequencer_tb_top

bind dbs_sequencer dbs_sequencer_props i_dbs_sequencer_props (.aclk(aclk), .aresetn(aresetn), .bias_ok(bias_ok),
	.enable_ok(enable_ok), .fault_in(fault_in), .overtemp(overtemp), .gate_out(gate_out),
	.power_on_ready(power_on_ready), .ss_ref_uv(ss_ref_uv), .startup_done(startup_done));
